// ---- inc/mdap_pkg.sv ----
// package: timing constants and command codes for the dram access controller
package mdap_pkg;

  // ************************************************************
  // clock and timing figures
  // ************************************************************
  localparam int CLK_NS                    = 40;      // 25 mhz clock period
  localparam int ROW_PRECHARGE_NS          = 90;      // row strobe high time between cycles
  localparam int ROW_STROBE_LOW_NS         = 120;     // least row strobe low width
  localparam int COL_STROBE_LOW_NS         = 30;      // least column strobe low width
  localparam int ROW_TO_COL_NS             = 25;      // row strobe to column strobe
  localparam int ROW_ACCESS_NS             = 120;     // row_access_time, slow grade
  localparam int OE_ACCESS_NS              = 30;      // output_enable_access_time
  localparam int OE_TURN_OFF_NS            = 30;      // output_enable_turn_off_time
  localparam int WRITE_DATA_HOLD_NS        = 25;      // write_data_hold
  localparam int REFRESH_COLUMN_SETUP_NS   = 10;      // refresh_column_setup
  localparam int REFRESH_COLUMN_HOLD_NS    = 30;      // refresh_column_hold
  localparam int POWERUP_WAIT_US           = 200;     // pause after power-up
  localparam int REFRESH_PERIOD_MS         = 8;       // all rows within this period
  localparam int INIT_CYCLES               = 8;       // row strobe cycles after pause
  localparam int ROWS                      = 512;     // rows to refresh

  // ************************************************************
  // derived cycle counts (least times rounded up)
  // ************************************************************
  function automatic int ns_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int PRE_CYC   = ns_up(ROW_PRECHARGE_NS);
  localparam int RAS_CYC   = ns_up(ROW_STROBE_LOW_NS);
  localparam int RCD_CYC   = ns_up(ROW_TO_COL_NS);
  localparam int CAS_CYC   = ns_up(ROW_ACCESS_NS + OE_ACCESS_NS);
  localparam int OEZ_CYC   = ns_up(OE_TURN_OFF_NS);
  localparam int DH_CYC    = ns_up(WRITE_DATA_HOLD_NS);
  localparam int CSR_CYC   = ns_up(REFRESH_COLUMN_SETUP_NS);
  localparam int CHR_CYC   = ns_up(REFRESH_COLUMN_HOLD_NS);
  // power-up pause and refresh interval (interval spread over all rows, rounded down)
  localparam int PWRUP_CYC = (POWERUP_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int REF_CYC   = (REFRESH_PERIOD_MS * 1000000 / ROWS) / CLK_NS;

  // ************************************************************
  // user command codes
  // ************************************************************
  localparam logic [1:0] CMD_READ  = 2'h0;   // read one word
  localparam logic [1:0] CMD_WRITE = 2'h1;   // early write one word
  localparam logic [1:0] CMD_RMW   = 2'h2;   // read then write same word

endpackage

// ---- design/mdap_ctrl.sv ----
// file: host controller driving an asynchronous 256k x 4 multiplexed dram
`timescale 1ns/1ps
//
// Functional notes
// - row then column, strobes latch address
// - both strobes high, precharge before next
// - never cut strobe low widths short
// - read keeps write strobe high
// - write strobe held high after strobes
// - output enable held to cover data
// - early write: write strobe before column
// - write data set before, held after
// - rmw: read first, then write strobe
// - column before row refresh entry timing
// - counter test column high width (no counter test here)
// - power-up pause then eight cycles
// - refresh each row within period
// - page mode keeps row strobe low (no page mode here: one column per row strobe)
module mdap_ctrl
  import mdap_pkg::*;
#(
  parameter int PWRUP_CYCLES  = PWRUP_CYC,   // shorten in simulation
  parameter int REF_INTERVAL  = REF_CYC,     // cycles between refreshes
  parameter int ADDR_W        = 9             // multiplexed address width
)(
  input  wire logic                i_clk,       // 25 mhz clock
  input  wire logic                i_srst,      // synchronous reset
  input  wire logic                i_req,       // request valid
  input  wire logic [1:0]          i_cmd,       // command code
  input  wire logic [2*ADDR_W-1:0] i_addr,      // row in high half, column low
  input  wire logic [3:0]          i_wdata,     // write word
  output logic                     o_ready,     // idle and initialised
  output logic                     o_rvalid,    // read word pulse
  output logic [3:0]               o_rdata,     // read word
  output logic                     o_ras_n,     // row strobe
  output logic                     o_cas_n,     // column strobe
  output logic                     o_we_n,      // write strobe
  output logic                     o_oe_n,      // output enable
  output logic [ADDR_W-1:0]        o_multiplexed_addr, // shared address pins
  input  wire logic [3:0]          i_shared_data_pins, // data pin level
  output logic [3:0]               o_shared_data_pins, // data drive value
  output logic                     o_shared_data_oe    // high while driving
);
  // ************************************************************
  // state and registers
  // ************************************************************
  typedef enum {ST_PWRUP, ST_INIT, ST_IDLE, ST_RAS, ST_CAS, ST_WR, ST_END,
                ST_PRE, ST_REF_CAS, ST_REF_RAS} mdap_state_e;
  mdap_state_e state;                   // main sequencer
  logic [31:0] cnt;                     // phase counter
  logic [31:0] ref_cnt;                 // refresh interval counter
  logic        ref_due;                 // refresh owed
  logic [3:0]  init_left;               // init cycles remaining
  logic [1:0]  cmd;                     // latched command
  logic [2*ADDR_W-1:0] addr;            // latched address
  logic [3:0]  wdata;                   // latched write word
  logic [3:0]  din_s1;                  // pin synchroniser stage one
  logic [3:0]  din_s2;                  // pin synchroniser stage two
  // ************************************************************
  // data pin synchroniser
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    din_s1 <= i_shared_data_pins;
    din_s2 <= din_s1;
  end
  // ************************************************************
  // refresh interval timer
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      ref_cnt <= 32'h0;
      ref_due <= 1'b0;
    end
    else if (state == ST_REF_RAS || ref_cnt >= 32'(REF_INTERVAL - 1))  // service or expiry
    begin
      ref_due <= (state != ST_REF_RAS);
      ref_cnt <= 32'h0;
    end
    else
    begin
      ref_cnt <= ref_cnt + 32'h1;
    end
  end

  // ************************************************************
  // main sequencer
  // ************************************************************
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      state              <= ST_PWRUP;
      cnt                <= 32'h0;
      init_left          <= 4'h0;
      cmd                <= CMD_READ;
      addr               <= '0;
      wdata              <= 4'h0;
      o_ready            <= 1'b0;
      o_rvalid           <= 1'b0;
      o_rdata            <= 4'h0;
      o_ras_n            <= 1'b1;
      o_cas_n            <= 1'b1;
      o_we_n             <= 1'b1;
      o_oe_n             <= 1'b1;
      o_multiplexed_addr <= '0;
      o_shared_data_pins <= 4'h0;
      o_shared_data_oe   <= 1'b0;
    end
    else
    begin
      o_rvalid <= 1'b0;
      cnt      <= cnt + 32'h1;
      case (state)
        // wait out the power-up pause
        ST_PWRUP:
        begin
          if (cnt >= 32'(PWRUP_CYCLES - 1))
          begin
            state     <= ST_INIT;
            init_left <= 4'(INIT_CYCLES);
            cnt       <= 32'h0;
          end
        end
        // eight row-only wake-up cycles, reusing the refresh path
        ST_INIT:
        begin
          if (init_left == 4'h0)
          begin
            state   <= ST_IDLE;
            o_ready <= 1'b1;
          end
          else
          begin
            init_left          <= init_left - 4'h1;
            o_ras_n            <= 1'b0;
            o_multiplexed_addr <= ADDR_W'(init_left);
            state              <= ST_END;
            cmd                <= 2'h3;              // no data phase
            cnt                <= 32'h0;
          end
        end
        // accept refresh first, then user work
        ST_IDLE:
        begin
          if (ref_due)
          begin
            o_ready <= 1'b0;
            o_cas_n <= 1'b0;
            state   <= ST_REF_CAS;
            cnt     <= 32'h0;
          end
          else if (i_req)
          begin
            o_ready            <= 1'b0;
            cmd                <= i_cmd;
            addr               <= i_addr;
            wdata              <= i_wdata;
            o_multiplexed_addr <= i_addr[2*ADDR_W-1:ADDR_W];
            state              <= ST_RAS;
            cnt                <= 32'h0;
          end
        end
        // drop row strobe with column high; early write strobe and data lead column
        ST_RAS:
        begin
          o_ras_n <= 1'b0;
          if (cmd == CMD_WRITE)
          begin
            o_we_n             <= 1'b0;
            o_shared_data_pins <= wdata;
            o_shared_data_oe   <= 1'b1;
          end
          state   <= ST_CAS;
          cnt     <= 32'h0;
        end
        // switch to column, one column per row strobe, drop column
        ST_CAS:
        begin
          if (cnt == 32'(RCD_CYC - 1))
          begin
            o_multiplexed_addr <= addr[ADDR_W-1:0];
            o_cas_n            <= 1'b0;
            if (cmd != CMD_WRITE)
              o_oe_n <= 1'b0;
            state <= ST_WR;
            cnt   <= 32'h0;
          end
        end
        // hold column low past access time, sample read data
        ST_WR:
        begin
          if (cnt == 32'(CAS_CYC + 2))
          begin
            if (cmd != CMD_WRITE)
            begin
              o_rdata  <= din_s2;
              o_rvalid <= 1'b1;
            end
            if (cmd == CMD_RMW)
              o_oe_n <= 1'b1;           // release before driving
            state <= ST_END;
            cnt   <= 32'h0;
          end
        end
        // rmw write phase, then strobes up after hold
        ST_END:
        begin
          if (cmd == CMD_RMW && cnt == 32'(OEZ_CYC))
          begin
            o_shared_data_pins <= wdata;
            o_shared_data_oe   <= 1'b1;
            o_we_n             <= 1'b0;
          end
          if (cnt >= 32'(RAS_CYC + OEZ_CYC + DH_CYC + 1))
          begin
            o_ras_n          <= 1'b1;
            o_cas_n          <= 1'b1;
            o_oe_n           <= 1'b1;
            o_we_n           <= 1'b1;
            o_shared_data_oe <= 1'b0;
            state            <= ST_PRE;
            cnt              <= 32'h0;
          end
        end
        // precharge, back to init or idle
        ST_PRE:
        begin
          if (cnt >= 32'(PRE_CYC - 1))
          begin
            state   <= (init_left != 4'h0 || cmd == 2'h3 && !o_ready) ? ST_INIT : ST_IDLE;
            o_ready <= !(init_left != 4'h0 || cmd == 2'h3 && !o_ready);
            cnt     <= 32'h0;
          end
        end
        // column low ahead of row for internal refresh
        ST_REF_CAS:
        begin
          if (cnt >= 32'(CSR_CYC - 1))
          begin
            o_ras_n <= 1'b0;
            state   <= ST_REF_RAS;
            cnt     <= 32'h0;
          end
        end
        // column stays low to the end, never re-strobed: no counter test
        ST_REF_RAS:
        begin
          if (cnt >= 32'(CHR_CYC - 1))
          begin
            cmd   <= 2'h3;
            state <= ST_END;
            cnt   <= 32'h0;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_read_we_high: assert property (@(posedge i_clk) disable iff (i_srst)
    (state == ST_WR && cmd == CMD_READ) |-> o_we_n) else $error("write strobe low in read");
  a_cas_after_ras: assert property (@(posedge i_clk) disable iff (i_srst)
    ($fell(o_cas_n) && state == ST_WR) |-> !o_ras_n) else $error("column fell before row");
  a_both_high_pre: assert property (@(posedge i_clk) disable iff (i_srst)
    (state == ST_PRE) |-> (o_ras_n && o_cas_n)) else $error("strobes not high in precharge");
  a_pre_width: assert property (@(posedge i_clk) disable iff (i_srst)
    $rose(o_ras_n) |-> o_ras_n [*3]) else $error("precharge too short");
  a_ras_width: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(o_ras_n) |-> !o_ras_n [*3]) else $error("row strobe low too short");
  a_ref_entry: assert property (@(posedge i_clk) disable iff (i_srst)
    ($fell(o_ras_n) && state == ST_REF_RAS) |-> !o_cas_n && !$past(o_cas_n))
    else $error("column not low before row in refresh");
  a_early_wr_oe: assert property (@(posedge i_clk) disable iff (i_srst)
    (!o_we_n && cmd == CMD_WRITE) |-> (o_oe_n && o_shared_data_oe)) else $error("oe low in write");
  a_no_contention: assert property (@(posedge i_clk) disable iff (i_srst)
    o_shared_data_oe |-> o_oe_n) else $error("controller drives while device enabled");
  a_data_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(o_we_n) |-> o_shared_data_oe [*2]) else $error("write data not held");
  c_read: cover property (@(posedge i_clk) o_rvalid && cmd == CMD_READ);
  c_write: cover property (@(posedge i_clk) $fell(o_we_n) && cmd == CMD_WRITE);
  c_rmw: cover property (@(posedge i_clk) $fell(o_we_n) && cmd == CMD_RMW);
  c_refresh: cover property (@(posedge i_clk) state == ST_REF_RAS);
endmodule // mdap_ctrl

// ---- dv/mdap_dram_model.sv ----
// behavioural 256k x 4 multiplexed dram that answers the controller
`timescale 1ns/1ps
module mdap_dram_model
(
  input  wire logic       i_ras_n,   // row strobe
  input  wire logic       i_cas_n,   // column strobe
  input  wire logic       i_we_n,    // write strobe
  input  wire logic       i_oe_n,    // output enable
  input  wire logic [8:0] i_addr,    // multiplexed address
  input  wire logic [3:0] i_dq,      // resolved data wire
  input  wire logic       i_slow,    // slow access when high
  output logic [3:0]      o_dq,      // read drive value
  output logic            o_dq_en,   // high while driving
  output int              o_viol,    // timing faults seen
  output int              o_ras_cnt, // row strobe cycles
  output int              o_acc_cnt, // addressed accesses
  output int              o_ref_cnt  // counter refreshes
);
  // ************************************************************
  // storage and strobe history
  // ************************************************************
  logic [3:0] mem [0:262143];
  logic [8:0] row;                  // latched row
  logic [8:0] col;                  // latched column
  logic [8:0] rcnt;                 // internal refresh row counter
  logic [3:0] q;                    // word latched for output
  logic [3:0] d;                    // write word under hold check
  logic       ew;                   // early write cycle
  logic       cbr;                  // column before row refresh
  logic       acc;                  // column latched in this strobe
  logic       ok;                   // access time has run out
  realtime    t_rf;                 // last row strobe fall
  realtime    t_rr;                 // last row strobe rise
  realtime    t_cf;                 // last column strobe fall

  // counters start clear, history far in the past
  initial
  begin
    o_viol = 0;
    o_ras_cnt = 0;
    o_acc_cnt = 0;
    o_ref_cnt = 0;
    rcnt = 9'h000;
    {ew, cbr, acc, ok} = 4'h0;
    t_rf = -1.0;
    t_rr = 0.0;
    t_cf = 0.0;
  end

  // drive only with column strobe and output enable low after an access, never in early write
  assign o_dq_en = !i_cas_n && !i_oe_n && !ew && acc;
  // invalid data until the access time has run out
  assign o_dq = ok ? q : ~q;

  // row strobe fall: row latch or refresh entry
  always @(negedge i_ras_n)
  begin
    if ($realtime - t_rr < 90.0) o_viol++;
    t_rf = $realtime;
    o_ras_cnt++;
    cbr = !i_cas_n;
    if (cbr && $realtime - t_cf < 10.0) o_viol++;
    if (cbr) rcnt++;
    if (cbr) o_ref_cnt++;
    row = i_addr;
  end

  // row strobe rise ends the cycle
  always @(posedge i_ras_n)
  begin
    if (t_rf >= 0.0 && $realtime - t_rf < 120.0) o_viol++;
    t_rr = $realtime;
  end

  // column strobe fall: column latch, early write, access timing
  always @(negedge i_cas_n)
  begin
    t_cf = $realtime;
    ok = 1'b0;
    if (!i_ras_n && !cbr)
    begin
      col = i_addr;
      ew = !i_we_n;
      acc = 1'b1;
      o_acc_cnt++;
      if (o_ras_cnt < 9) o_viol++;
      q = mem[{row, col}];
      #1.0;
      d = i_dq;
      if (ew) mem[{row, col}] = d;
      #24.0;
      if (ew && i_dq !== d) o_viol++;
      #(i_slow ? 95.0 : 55.0);
      ok = 1'b1;
    end
    // column re-strobed after a refresh entry: counter test, never expected
    else if (!i_ras_n)
      o_viol++;
  end

  // write strobe late: read-modify-write stores the word on the pins
  always @(negedge i_we_n)
  begin
    if (!i_cas_n && !i_ras_n && acc && !ew)
    begin
      if ($realtime - t_cf < 70.0 || $realtime - t_rf < 160.0) o_viol++;
      #1.0;
      d = i_dq;
      mem[{row, col}] = d;
      #24.0;
      if (i_dq !== d) o_viol++;
    end
  end

  // column strobe rise: low width and refresh hold
  always @(posedge i_cas_n)
  begin
    if (acc && $realtime - t_cf < 30.0) o_viol++;
    if (cbr && !i_ras_n && $realtime - t_rf < 30.0) o_viol++;
    acc = 1'b0;
  end
endmodule // mdap_dram_model

// ---- dv/multiplexed_dram_access_port_test.sv ----
// self-checking bench for the multiplexed dram access controller
`timescale 1ns/1ps
module multiplexed_dram_access_port_test
  import mdap_pkg::*;
;
  // ************************************************************
  // stimulus, wiring and bookkeeping
  // ************************************************************
  localparam int PWR = 20;                   // shortened power-up pause
  localparam int REF = 100;                  // shortened refresh interval
  logic        clk = 1'b0;                   // 25 mhz clock
  logic        srst = 1'b1;                  // reset held at start
  logic        req = 1'b0;                   // request level
  logic        slow = 1'b0;                  // slow model answers
  logic [1:0]  cmd = 2'h0;                   // command code
  logic [17:0] addr = 18'h00000;             // word address
  logic [3:0]  wdata = 4'h0;                 // write word
  logic [3:0]  flt = 4'h0;                   // level of an undriven wire
  logic [3:0]  rd;                           // word returned by an op
  logic        ready, rvalid, ras_n, cas_n, we_n, oe_n, c_oe, m_en;
  logic [3:0]  rdata, c_dq, m_dq, dq;
  logic [8:0]  maddr;
  int          err_count = 0;
  int          cmp_count = 0;
  int          seed = 77746;
  int          viol, ras_cnt, acc_cnt, ref_cnt;
  int          gap = 0, gap_max = 0, last_ref = 0, cyc = 0;
  logic [3:0]  ref_mem [logic [17:0]];       // expected contents
  logic [17:0] used [$];                     // addresses written so far
  logic [17:0] corner [5] = '{18'h00000, 18'h3ffff, 18'h001ff, 18'h3fe00, 18'h00200};

  // either party drives, otherwise a level that keeps moving
  assign dq = c_oe ? c_dq : (m_en ? m_dq : flt);

  mdap_ctrl #(.PWRUP_CYCLES(PWR), .REF_INTERVAL(REF)) uut (
    .i_clk(clk), .i_srst(srst), .i_req(req), .i_cmd(cmd), .i_addr(addr),
    .i_wdata(wdata), .o_ready(ready), .o_rvalid(rvalid), .o_rdata(rdata),
    .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_oe_n(oe_n),
    .o_multiplexed_addr(maddr), .i_shared_data_pins(dq),
    .o_shared_data_pins(c_dq), .o_shared_data_oe(c_oe));

  mdap_dram_model m (
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_addr(maddr), .i_dq(dq), .i_slow(slow), .o_dq(m_dq), .o_dq_en(m_en),
    .o_viol(viol), .o_ras_cnt(ras_cnt), .o_acc_cnt(acc_cnt), .o_ref_cnt(ref_cnt));

  always #20 clk = ~clk;

  // floating level, refresh spacing, pin contention
  always @(posedge clk)
  begin
    flt <= flt + 4'h5;
    cyc++;
    gap = (ref_cnt != last_ref) ? 0 : gap + 1;
    last_ref = ref_cnt;
    if (gap > gap_max) gap_max = gap;
    if (c_oe && m_en) chk(1, 0);
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a wait that ran out
  task automatic hang;
    chk(0, 1);
    give_verdict();
  endtask

  // expected word at an address
  function automatic logic [3:0] expect_of(input logic [17:0] a);
    return ref_mem.exists(a) ? ref_mem[a] : 4'hx;
  endfunction

  // one request, retried if a refresh took the slot
  task automatic do_op(input logic [1:0] c, input logic [17:0] a, input logic [3:0] w);
    int n;
    int a0;
    bit done;
    done = 0;
    rd = 4'hx;
    for (int k = 0; k < 4 && !done; k++)
    begin
      n = 0;
      while (!ready && n < 200)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      if (n >= 200) hang();
      a0 = acc_cnt;
      req = 1'b1;
      cmd = c;
      addr = a;
      wdata = w;
      @(posedge clk);
      #1;
      req = 1'b0;
      n = 0;
      while ((n < 3 || !ready) && n < 200)
      begin
        if (rvalid) rd = rdata;
        @(posedge clk);
        #1;
        n++;
      end
      if (n >= 200) hang();
      done = (acc_cnt != a0);
    end
    if (!done) hang();
  endtask

  // op plus checks of returned word and stored word
  task automatic op_chk(input logic [1:0] c, input logic [17:0] a, input logic [3:0] w);
    do_op(c, a, w);
    if (c != CMD_WRITE) chk(rd, expect_of(a));
    if (c != CMD_READ) ref_mem[a] = w;
    if (c != CMD_READ) used.push_back(a);
    chk(m.mem[a], expect_of(a));
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    int n;
    int r;
    logic [17:0] a;
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
    cyc = 0;
    n = 0;
    while (!ready && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 2000) hang();
    chk(cyc > PWR, 1);
    chk(ras_cnt >= 8, 1);
    gap_max = 0;
    gap = 0;
    $display("init test done");
    // corner addresses, every command back to back
    foreach (corner[i])
    begin
      op_chk(CMD_WRITE, corner[i], 4'(i * 3 + 1));
      op_chk(CMD_READ, corner[i], 4'h0);
      op_chk(CMD_RMW, corner[i], 4'(~(i * 3 + 1)));
    end
    $display("corner test done");
    // random mix with prompt and slow answers
    for (int i = 0; i < 40; i++)
    begin
      slow = 1'($random(seed));
      r = {$random(seed)} % 3;
      a = (r == 1) ? 18'($random(seed)) : used[{$random(seed)} % used.size()];
      op_chk(2'(r), a, 4'($random(seed)));
    end
    $display("random test done");
    // idle time lets refresh run on its own
    repeat (400) @(posedge clk);
    chk(ref_cnt > 4, 1);
    chk(gap_max <= REF + 30, 1);
    chk(m.rcnt, 9'(ref_cnt));
    chk(viol, 0);
    $display("refresh test done");
    give_verdict();
  end
endmodule // multiplexed_dram_access_port_test
